// File: logic/crs_select.sv
// Function
// - broadcast bit writes all four channels
// - reads come from indexed channel only
// - channel access only with enable set
// - enabled address zero hits channel register
// - enable clear routes to shared set
// - write to top address loads select
// - select register reads return invalid value
// - zero shared, four-seven single channel
// - twelve-fifteen broadcast write, indexed read
// - selection holds until select rewritten
// - four independent channel register copies
// - select register resets to zero
`timescale 1ns/10ps
`default_nettype none

module crs_select #(
  parameter int CH_DEPTH = crs_pkg::CH_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire crs_pkg::crs_req_t req,
  input wire logic [7:0] sh_rdata,
  output var crs_pkg::crs_req_t sh_req,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output var crs_pkg::crs_sel_t sel_state
);

  // ==========================================================
  // decode helpers
  // channel ch takes a write under selection s
  function automatic logic ch_write_hit(input crs_pkg::crs_sel_t s, input int ch);
    logic idx_hit;
    idx_hit = (s.target_channel_index == ch[1:0]);
    ch_write_hit = s.channel_space_enable && (s.broadcast_write_select || idx_hit);
  endfunction

  // ==========================================================
  // state
  crs_pkg::crs_sel_t sel_reg;
  crs_pkg::crs_req_t sh_req_reg;
  crs_pkg::crs_src_t src_reg;
  logic rd_pend_reg;
  logic [7:0] ch_rdata_reg;
  logic rd_valid_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] ch_mem [crs_pkg::NUM_CH][CH_DEPTH];

  // ==========================================================
  // request decode
  wire logic is_sel_addr = (req.addr == crs_pkg::SEL_ADDR);
  wire logic sel_wr = req.wr && is_sel_addr;
  wire logic sel_rd = req.rd && is_sel_addr;
  wire logic to_chan = sel_reg.channel_space_enable && !is_sel_addr;
  wire logic to_shared = !sel_reg.channel_space_enable && !is_sel_addr;
  wire logic [3:0] sel_next_raw = req.wdata[3:0];
  wire crs_pkg::crs_sel_t sel_next = crs_pkg::crs_sel_t'(sel_next_raw);
  wire logic [1:0] rd_idx = sel_reg.target_channel_index;
  wire logic [7:0] ch_rd_word = ch_mem[rd_idx][req.addr];
  wire crs_pkg::crs_src_t src_next = is_sel_addr ? crs_pkg::CRS_SRC_INVALID :
                                     (to_chan ? crs_pkg::CRS_SRC_CHAN : crs_pkg::CRS_SRC_SHARED);
  wire logic [7:0] rd_data_next = (src_reg == crs_pkg::CRS_SRC_CHAN) ? ch_rdata_reg :
                                  (src_reg == crs_pkg::CRS_SRC_SHARED) ? sh_rdata :
                                  crs_pkg::INVALID_RDATA;
  wire logic [crs_pkg::NUM_CH-1:0] ch_we;

  // ==========================================================
  // select register, upper four bits dropped
  // top address always loads select
  // held until the next select write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_reg <= crs_pkg::crs_sel_t'(crs_pkg::SEL_RESET);
    end else if (sel_wr) begin
      sel_reg <= sel_next;
    end
  end

  // ==========================================================
  // channel register copies, one per channel
  // separate copy per channel
  genvar g;
  generate
    for (g = 0; g < crs_pkg::NUM_CH; g++) begin : g_ch
      assign ch_we[g] = req.wr && !is_sel_addr && ch_write_hit(sel_reg, g);
      always_ff @(posedge clk) begin
        if (ch_we[g]) begin
          ch_mem[g][req.addr] <= req.wdata;
        end
      end
    end
  endgenerate

  // ==========================================================
  // shared set request, only while channel space is off
  // shared routing when enable clear
  // enabled accesses kept off shared set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_req_reg <= '0;
    end else begin
      sh_req_reg.wr <= req.wr && to_shared;
      sh_req_reg.rd <= req.rd && to_shared;
      sh_req_reg.addr <= req.addr;
      sh_req_reg.wdata <= req.wdata;
    end
  end

  // ==========================================================
  // read stage one: capture source and channel word
  // read from indexed channel only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_pend_reg <= 1'b0;
      src_reg <= crs_pkg::CRS_SRC_SHARED;
      ch_rdata_reg <= '0;
    end else begin
      rd_pend_reg <= req.rd;
      src_reg <= src_next;
      ch_rdata_reg <= ch_rd_word;
    end
  end

  // ==========================================================
  // read stage two: answer
  // select register reads give invalid value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
    end else begin
      rd_valid_reg <= rd_pend_reg;
      rd_data_reg <= rd_pend_reg ? rd_data_next : '0;
    end
  end

  // outputs straight from flops
  assign sh_req = sh_req_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign sel_state = sel_reg;

  // ==========================================================
  // checks
  logic sel_seen_reg;

  // helper: a select write has happened since reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_seen_reg <= 1'b0;
    end else if (sel_wr) begin
      sel_seen_reg <= 1'b1;
    end
  end

  sequence s_chan_write;
    req.wr && to_chan;
  endsequence

  sequence s_chan_read;
    req.rd && !req.wr && to_chan;
  endsequence

  sequence s_answer(logic [7:0] v);
    ##2 (rd_valid && rd_data == v);
  endsequence

  sequence s_bcast_write;
    req.wr && to_chan && sel_reg.broadcast_write_select;
  endsequence

  sequence s_single_write;
    req.wr && to_chan && !sel_reg.broadcast_write_select;
  endsequence

  sequence s_shared_read;
    req.rd && !req.wr && to_shared;
  endsequence

  // forwarded one cycle on, answered the cycle after
  sequence s_shared_answer;
    ##1 sh_req_reg.rd ##1 (rd_valid && rd_data == $past(sh_rdata));
  endsequence

  a_sel_reset_zero: assert property (@(posedge clk) disable iff (!rstn)
    !sel_seen_reg |-> (sel_reg == crs_pkg::crs_sel_t'(crs_pkg::SEL_RESET)))
    else $error("select not zero before first write");

  a_sel_write_load: assert property (@(posedge clk) disable iff (!rstn)
    sel_wr |=> (sel_reg == $past(sel_next_raw)))
    else $error("select write not loaded");

  a_sel_hold: assert property (@(posedge clk) disable iff (!rstn)
    !sel_wr |=> $stable(sel_reg))
    else $error("select changed without write");

  a_bcast_all_ch: assert property (@(posedge clk) disable iff (!rstn)
    s_bcast_write |=>
      (ch_mem[0][$past(req.addr)] == $past(req.wdata)) &&
      (ch_mem[1][$past(req.addr)] == $past(req.wdata)) &&
      (ch_mem[2][$past(req.addr)] == $past(req.wdata)) &&
      (ch_mem[3][$past(req.addr)] == $past(req.wdata)))
    else $error("broadcast write missed a channel");

  a_single_ch_write: assert property (@(posedge clk) disable iff (!rstn)
    s_single_write |->
      (ch_we == (4'b0001 << sel_reg.target_channel_index)))
    else $error("single channel write enable wrong");

  a_read_indexed: assert property (@(posedge clk) disable iff (!rstn)
    s_chan_read |-> ##2 (rd_valid && rd_data == $past(ch_mem[rd_idx][req.addr], 2)))
    else $error("channel read returned wrong data");

  a_no_ch_disabled: assert property (@(posedge clk) disable iff (!rstn)
    !sel_reg.channel_space_enable |-> (ch_we == '0))
    else $error("channel write while channel space off");

  a_addr0_to_chan: assert property (@(posedge clk) disable iff (!rstn)
    ((req.wr || req.rd) && sel_reg.channel_space_enable) |=> !sh_req_reg.wr && !sh_req_reg.rd)
    else $error("shared set reached while channel space on");

  a_shared_route: assert property (@(posedge clk) disable iff (!rstn)
    (req.wr && to_shared) |=> sh_req_reg.wr && (sh_req_reg.addr == $past(req.addr)))
    else $error("shared write not forwarded");

  a_sel_rd_invalid: assert property (@(posedge clk) disable iff (!rstn)
    (sel_rd && !req.wr) |-> s_answer(crs_pkg::INVALID_RDATA))
    else $error("select read not invalid");

  a_bcast_needs_en: assert property (@(posedge clk) disable iff (!rstn)
    (sel_reg.broadcast_write_select && !sel_reg.channel_space_enable && req.wr) |->
      (ch_we == '0) ##1 (sh_req_reg.wr || $past(is_sel_addr)))
    else $error("broadcast acted without enable");

  // ==========================================================
  // routing isolation and answer timing

  // broadcast raises every channel enable
  a_bcast_we_all: assert property (@(posedge clk) disable iff (!rstn)
    s_bcast_write |-> (ch_we == '1))
    else $error("broadcast write missed an enable");

  // enables are none, one or all
  a_we_shape: assert property (@(posedge clk) disable iff (!rstn)
    $onehot0(ch_we) || (ch_we == '1))
    else $error("channel enables mixed");

  // no request, no channel write
  a_idle_no_write: assert property (@(posedge clk) disable iff (!rstn)
    !req.wr |-> (ch_we == '0))
    else $error("channel written without request");

  // select write touches neither set
  a_sel_wr_isolated: assert property (@(posedge clk) disable iff (!rstn)
    sel_wr |-> (ch_we == '0) ##1 !sh_req_reg.wr)
    else $error("select write leaked to a register set");

  // upper nibble dropped on load
  a_upper_ignored: assert property (@(posedge clk) disable iff (!rstn)
    sel_wr |=> (sel_state == $past(req.wdata[3:0])))
    else $error("select state not low nibble");

  // select read starts no shared access
  a_sel_rd_no_shared: assert property (@(posedge clk) disable iff (!rstn)
    sel_rd |=> !sh_req_reg.rd)
    else $error("select read reached shared set");

  // channel traffic stays off shared set
  a_chan_wr_no_shared: assert property (@(posedge clk) disable iff (!rstn)
    s_chan_write |=> !sh_req_reg.wr)
    else $error("channel write reached shared set");

  a_chan_rd_no_shared: assert property (@(posedge clk) disable iff (!rstn)
    s_chan_read |=> !sh_req_reg.rd)
    else $error("channel read reached shared set");

  // shared read forwarded and answered
  a_shared_read: assert property (@(posedge clk) disable iff (!rstn)
    s_shared_read |-> s_shared_answer)
    else $error("shared read not answered");

  // shared write data copied through
  a_sh_wdata_copy: assert property (@(posedge clk) disable iff (!rstn)
    (req.wr && to_shared) |=> (sh_req_reg.wdata == $past(req.wdata)))
    else $error("shared write data not forwarded");

  // every read answered two cycles on
  a_read_latency: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && !req.wr) |-> ##2 rd_valid)
    else $error("read answer late");

  // answer bus quiet between answers
  a_rd_data_idle: assert property (@(posedge clk) disable iff (!rstn)
    !rd_valid |-> (rd_data == '0))
    else $error("read data not quiet");

endmodule

`default_nettype wire

// File: logic/crs_pkg.sv
package crs_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] SEL_ADDR = 8'h00_ff;      // register_set_select
  localparam logic [7:0] CH_REG_ZERO_ADDR = 8'h00_00;  // channel_reg_zero
  localparam int NUM_CH = 4;
  localparam int CH_DEPTH = 256;

  // ==========================================================
  // select register fields and reset value
  localparam int SEL_BCAST_BIT = 3;
  localparam int SEL_EN_BIT = 2;
  localparam int SEL_IDX_LSB = 0;
  localparam int SEL_IDX_W = 2;
  localparam logic [3:0] SEL_RESET = 4'h0;
  // value returned for a read of the write-only select register
  localparam logic [7:0] INVALID_RDATA = 8'h00_ee;

  // ==========================================================
  // read source codes of the first pipeline stage
  typedef enum logic [1:0] {
    CRS_SRC_SHARED = 2'b00,
    CRS_SRC_CHAN = 2'b01,
    CRS_SRC_INVALID = 2'b11
  } crs_src_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic broadcast_write_select;
    logic channel_space_enable;
    logic [1:0] target_channel_index;
  } crs_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crs_req_t;

endpackage

// File: bench/crs_shared_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// shared register set standing behind the select block
module crs_shared_model (
  input wire logic clk,
  input wire crs_pkg::crs_req_t sh_req,
  output logic [7:0] sh_rdata
);
  logic [7:0] mem [256];

  // known start contents
  initial begin
    foreach (mem[i]) mem[i] = 8'h00_00;
  end

  // read data follows the address at once
  assign sh_rdata = mem[sh_req.addr];

  // one byte stored per write pulse
  always @(posedge clk) begin
    if (sh_req.wr) begin
      mem[sh_req.addr] <= sh_req.wdata;
    end
  end
endmodule

`default_nettype wire

// File: bench/channel_register_set_select_bench.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// register routing bench
module channel_register_set_select_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  crs_pkg::crs_req_t req = '0;
  crs_pkg::crs_req_t sh_req;
  logic [7:0] sh_rdata;
  logic [7:0] rd_data;
  logic rd_valid;
  crs_pkg::crs_sel_t sel_state;
  int n_mismatch = 0;
  int cmp_count = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  crs_select i_crs_select (.clk(clk), .rstn(rstn), .req(req), .sh_rdata(sh_rdata),
    .sh_req(sh_req), .rd_valid(rd_valid), .rd_data(rd_data), .sel_state(sel_state));
  crs_shared_model i_crs_shared_model (.clk(clk), .sh_req(sh_req), .sh_rdata(sh_rdata));

  // verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask

  // one-cycle read pulse, bounded wait for the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00_00};
    @(posedge clk);
    req <= '0;
    #1;
    for (n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (rd_valid !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t no read answer", $time);
      final_report();
    end else begin
      chk(rd_data, exp);
    end
  endtask

  // full byte to the select register, upper nibble zero
  task automatic sel(input logic [7:0] v);
    wr(crs_pkg::SEL_ADDR, v);
    chk({4'h0, sel_state}, v);
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({4'h0, sel_state}, 8'h00_00);
    wr(8'h00_00, 8'h00_11);
    rd(8'h00_00, 8'h00_11);
    for (int i = 0; i < 4; i++) begin
      sel(8'(i) + 8'h00_04);
      wr(8'h00_00, 8'(i) + 8'h00_20);
    end
    for (int i = 0; i < 4; i++) begin
      sel(8'(i) + 8'h00_04);
      rd(8'h00_00, 8'(i) + 8'h00_20);
    end
    sel(8'h00_0c);
    wr(8'h00_03, 8'h00_5a);
    for (int i = 0; i < 4; i++) begin
      sel(8'(i) + 8'h00_0c);
      rd(8'h00_03, 8'h00_5a);
      rd(8'h00_00, 8'(i) + 8'h00_20);
    end
    rd(crs_pkg::SEL_ADDR, crs_pkg::INVALID_RDATA);
    sel(8'h00_08);
    wr(8'h00_00, 8'h00_33);
    sel(8'h00_04);
    rd(8'h00_00, 8'h00_20);
    sel(8'h00_00);
    rd(8'h00_00, 8'h00_33);
    final_report();
  end
endmodule

`default_nettype wire
